// ---- design/texture_combiner_pkg.sv ----
// Package with register map, field layouts and pixel carriers of the combiner.
package texture_combiner_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the APB window.
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] PRIO_OFF = 8'h04;
	localparam logic [7:0] TEX_A_OFF = 8'h08;
	localparam logic [7:0] TEX_B_OFF = 8'h0C;
	localparam logic [7:0] CROP_A_H_OFF = 8'h10;
	localparam logic [7:0] CROP_A_V_OFF = 8'h14;
	localparam logic [7:0] CROP_B_H_OFF = 8'h18;
	localparam logic [7:0] CROP_B_V_OFF = 8'h1C;
	localparam logic [7:0] STATUS_OFF = 8'h20;

	////////////////////////////////////////////////////////////////////////
	// Value limits and arithmetic constants.
	localparam int CROSSFADE_MAX = 100;
	localparam int PRIO_OFFSET_MAX = 100;
	localparam int PRIO_OFFSET_STEP = 25;
	localparam int GAIN_MAX = 50;
	localparam int WEIGHT_ONE = 256;
	localparam int WEIGHT_HALF = 128;
	localparam int SOFT_HARD = 7;
	localparam int LUMA_MID = 128;
	localparam int GAIN_SHIFT = 2;
	localparam int NUM_EXT_INPUTS = 12;
	localparam int PIPE_LATENCY = 1;

	// Texture source codes above the external inputs 1 to 12 (codes 0-11).
	localparam logic [3:0] SRC_PATTERN = 4'hC;
	localparam logic [3:0] SRC_DEFOCUS_A = 4'hD;
	localparam logic [3:0] SRC_DEFOCUS_B = 4'hE;
	localparam logic [3:0] SRC_MATTE = 4'hF;

	////////////////////////////////////////////////////////////////////////
	// Mode encodings.
	typedef enum logic [1:0] {
		TEX_OFF = 2'h0,
		TEX_ON = 2'h1,
		TEX_INVERT = 2'h2
	} tex_main_type;

	typedef enum logic [1:0] {
		FRZ_LIVE = 2'h0,
		FRZ_FIELD1 = 2'h1,
		FRZ_FIELD2 = 2'h2,
		FRZ_FRAME = 2'h3
	} freeze_type;

	typedef enum logic [1:0] {
		CROP_OFF = 2'h0,
		CROP_ON = 2'h1,
		CROP_INVERT = 2'h2
	} crop_mode_type;

	////////////////////////////////////////////////////////////////////////
	// Register layouts, most significant field first.
	typedef struct packed {
		logic [20:0] rsvd;
		logic [6:0] crossfade_amount;
		logic [2:0] z_soft;
		logic depth_mode;
	} ctrl_reg_type;

	typedef struct packed {
		logic [15:0] rsvd;
		logic signed [7:0] b_offset;
		logic signed [7:0] a_offset;
	} prio_reg_type;

	typedef struct packed {
		logic signed [7:0] gain;
		logic signed [7:0] offset;
		logic [3:0] rsvd;
		logic [3:0] source;
		crop_mode_type crop;
		freeze_type vid_freeze;
		freeze_type tex_freeze;
		tex_main_type main_fn;
	} tex_reg_type;

	typedef struct packed {
		logic [4:0] rsvd_hi;
		logic [10:0] hi;
		logic [4:0] rsvd_lo;
		logic [10:0] lo;
	} crop_pair_type;

	// Reset values of the writable registers.
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] PRIO_RST = 32'h0000_0000;
	localparam logic [31:0] TEX_RST = 32'h0100_0000;
	localparam logic [31:0] CROP_RST = 32'h07FF_0000;

	////////////////////////////////////////////////////////////////////////
	// Pixel carriers.
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] key;
		logic signed [15:0] z;
		logic signed [7:0] nx;
		logic signed [7:0] ny;
	} chan_pixel_type;

	typedef struct packed {
		logic signed [7:0] nx;
		logic signed [7:0] ny;
	} normals_type;

	typedef struct packed {
		logic [11:0][7:0] ext;
		logic [7:0] pattern;
		logic [7:0] defocus_a;
		logic [7:0] defocus_b;
		logic [7:0] matte;
	} tex_sources_type;

	typedef struct packed {
		logic valid;
		logic line_start;
		logic field2;
		logic [10:0] x;
		logic [10:0] y;
	} raster_type;

endpackage

// ---- design/texture_combiner.sv ----
// Channel pair priority combiner with texture relief on surface normals.
//
// Summary of operation
// - Fixed mode puts one channel over the other whatever the depths; A default.
// - Crossfade 0 shows A over B, 100 B over A, between blends.
// - Depth mode puts the channel with the lower depth value in front.
// - Depth compares per pixel, so a rotated channel wins only nearer parts.
// - Per channel priority offset, default 0, range +/-100, snapped to 25 steps.
// - Intersection softness 0..7, 0 softest blend, 7 hard cut, default 0.
// - Texture luminance becomes depth; brighter raises, darker lowers the surface.
// - Texture bends only the normals to lighting, never the picture values.
// - Uniform luminance yields flat normals whatever its absolute level.
// - Each channel picks its own texture source; default is input 1.
// - One shared pattern store outside; per channel texture and video freezes.
// - Texture freeze: live, field 1 only, field 2 only, or full frame.
// - Texture offset shifts mean relief height, clipping flat at range ends.
// - Gain scales relief slope; zero removes it, negative inverts it.
// - Main set to invert flips texture source polarity before relief.
// - Crop on applies texture inside the edges; invert applies it outside.
// - Texture offset accepts -128 to +127, default zero.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

module texture_combiner
	import texture_combiner_pkg::*;
#(
	parameter int FRZ_PIXELS = 64,
	parameter int Z_OFFSET_SCALE = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire raster_type raster,
	input wire chan_pixel_type chan_a,
	input wire chan_pixel_type chan_b,
	input wire tex_sources_type tex_src,
	output logic out_valid,
	output logic [7:0] out_y,
	output logic [7:0] out_key,
	output normals_type normal_a,
	output normals_type normal_b
);

	localparam int FRZ_AW = $clog2(FRZ_PIXELS);
	localparam int FRZ_DEPTH = 2 * FRZ_PIXELS;

	////////////////////////////////////////////////////////////////////////
	// Whole module state. The freeze stores hold one stripe of FRZ_PIXELS
	// pixels per field, repeated down the picture, to keep flop count sane.
	typedef struct packed {
		ctrl_reg_type ctrl;
		prio_reg_type prio;
		tex_reg_type [1:0] tex;
		crop_pair_type [1:0] crop_h;
		crop_pair_type [1:0] crop_v;
		logic [1:0][FRZ_DEPTH-1:0][7:0] tex_mem;
		logic [1:0][FRZ_DEPTH-1:0][7:0] vid_mem;
		logic [1:0][7:0] h_prev;
		logic out_valid;
		logic [7:0] out_y;
		logic [7:0] out_key;
		normals_type [1:0] normal;
		logic [2:0] status;
	} state_type;

	state_type q;
	state_type d;
	logic wr_en;
	logic rd_en;
	logic addr_hit;

	////////////////////////////////////////////////////////////////////////
	// Helper arithmetic.

	// Saturate to a signed byte.
	function automatic logic [7:0] sat8(input int v);
		if (v > 127) begin
			return 8'h7F;
		end
		if (v < -128) begin
			return 8'h80;
		end
		return 8'(v);
	endfunction

	function automatic int clampi(input int v, input int lo, input int hi);
		if (v < lo) begin
			return lo;
		end
		if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// Priority offsets land on the nearest 25 step inside +/-100.
	function automatic logic [7:0] snap25(input logic [7:0] raw);
		int v;
		int m;
		v = clampi(int'(signed'(raw)), -PRIO_OFFSET_MAX, PRIO_OFFSET_MAX);
		m = v < 0 ? -v : v;
		m = ((m + PRIO_OFFSET_STEP / 2) / PRIO_OFFSET_STEP) * PRIO_OFFSET_STEP;
		return 8'(v < 0 ? -m : m);
	endfunction

	// Shaped composite of front over back; returns {key, luma}.
	function automatic logic [15:0] over(input logic [7:0] yf,
		input logic [7:0] kf8, input logic [7:0] yb, input logic [7:0] kb8);
		int kf;
		int kb;
		int yb_sh;
		int y;
		int k;
		kf = int'(kf8) + int'(kf8[7]);
		kb = int'(kb8) + int'(kb8[7]);
		yb_sh = (int'(yb) * kb) >> 8;
		y = (int'(yf) * kf + yb_sh * (WEIGHT_ONE - kf)) >> 8;
		k = clampi(kf + ((kb * (WEIGHT_ONE - kf)) >> 8), 0, 255);
		return {8'(k), 8'(clampi(y, 0, 255))};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB handshake: zero wait states, error on unmapped addresses.
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;

	always_comb begin
		addr_hit = 1'b1;
		unique case (paddr)
			CTRL_OFF: prdata = q.ctrl;
			PRIO_OFF: prdata = q.prio;
			TEX_A_OFF: prdata = q.tex[0];
			TEX_B_OFF: prdata = q.tex[1];
			CROP_A_H_OFF: prdata = q.crop_h[0];
			CROP_A_V_OFF: prdata = q.crop_v[0];
			CROP_B_H_OFF: prdata = q.crop_h[1];
			CROP_B_V_OFF: prdata = q.crop_v[1];
			STATUS_OFF: prdata = {29'h0, q.status};
			default: begin
				prdata = 32'h0000_0000;
				addr_hit = 1'b0;
			end
		endcase
	end

	assign pslverr = (wr_en | rd_en) & ~addr_hit;

	////////////////////////////////////////////////////////////////////////
	// Next state: register writes, texture relief and priority compositing.
	always_comb begin
		chan_pixel_type ch [2];
		logic [7:0] src_l;
		logic [7:0] vid_l;
		logic [7:0] lum;
		logic [FRZ_AW:0] wr_idx;
		logic [FRZ_AW:0] rd_idx;
		logic in_crop;
		logic apply;
		logic [7:0] h;
		logic [7:0] vid_y [2];
		logic [15:0] ab;
		logic [15:0] ba;
		int c;
		int hdiff;
		int slope;
		int za;
		int zb;
		int diff;
		int wa;
		tex_reg_type tw;
		c = 0;
		ch[0] = chan_a;
		ch[1] = chan_b;
		src_l = 8'h00;
		vid_l = 8'h00;
		lum = 8'h00;
		wr_idx = {raster.field2, raster.x[FRZ_AW-1:0]};
		rd_idx = '0;
		in_crop = 1'b0;
		apply = 1'b0;
		h = 8'h00;
		vid_y[0] = 8'h00;
		vid_y[1] = 8'h00;
		ab = 16'h0000;
		ba = 16'h0000;
		hdiff = 0;
		slope = 0;
		za = 0;
		zb = 0;
		diff = 0;
		wa = 0;
		tw = tex_reg_type'(pwdata);
		d = q;

		// Register writes; out-of-range values are clamped or snapped.
		if (wr_en) begin
			unique case (paddr)
				CTRL_OFF: begin
					d.ctrl.depth_mode = pwdata[0];
					d.ctrl.z_soft = pwdata[3:1];
					d.ctrl.crossfade_amount = 7'(clampi(int'(pwdata[10:4]),
						0, CROSSFADE_MAX));
				end
				PRIO_OFF: begin
					d.prio.a_offset = snap25(pwdata[7:0]);
					d.prio.b_offset = snap25(pwdata[15:8]);
				end
				TEX_A_OFF, TEX_B_OFF: begin
					// Full signed byte, so -128..+127 is taken as is.
					tw.rsvd = 4'h0;
					tw.gain = sat8(clampi(int'(tw.gain), -GAIN_MAX, GAIN_MAX));
					d.tex[paddr == TEX_B_OFF] = tw;
				end
				CROP_A_H_OFF: d.crop_h[0] = pwdata & CROP_RST | pwdata & 32'h0000_07FF;
				CROP_A_V_OFF: d.crop_v[0] = pwdata & CROP_RST | pwdata & 32'h0000_07FF;
				CROP_B_H_OFF: d.crop_h[1] = pwdata & CROP_RST | pwdata & 32'h0000_07FF;
				CROP_B_V_OFF: d.crop_v[1] = pwdata & CROP_RST | pwdata & 32'h0000_07FF;
				default: d.status = q.status;
			endcase
		end

		// Per channel texture path and video freeze, identical for A and B.
		for (c = 0; c < 2; c++) begin
			// Own source per channel; the pattern store is only an input here,
			// with no path from live video into it.
			if (q.tex[c].source < 4'(NUM_EXT_INPUTS)) begin
				src_l = tex_src.ext[q.tex[c].source];
			end else if (q.tex[c].source == SRC_PATTERN) begin
				src_l = tex_src.pattern;
			end else if (q.tex[c].source == SRC_DEFOCUS_A) begin
				src_l = tex_src.defocus_a;
			end else if (q.tex[c].source == SRC_DEFOCUS_B) begin
				src_l = tex_src.defocus_b;
			end else begin
				src_l = tex_src.matte;
			end

			// Freeze stores follow the live pixels until frozen, then hold.
			if (raster.valid && q.tex[c].tex_freeze == FRZ_LIVE) begin
				d.tex_mem[c][wr_idx] = src_l;
			end
			if (raster.valid && q.tex[c].vid_freeze == FRZ_LIVE) begin
				d.vid_mem[c][wr_idx] = ch[c].y;
			end

			unique case (q.tex[c].tex_freeze)
				FRZ_FIELD1: rd_idx = {1'b0, wr_idx[FRZ_AW-1:0]};
				FRZ_FIELD2: rd_idx = {1'b1, wr_idx[FRZ_AW-1:0]};
				FRZ_FRAME: rd_idx = wr_idx;
				default: rd_idx = wr_idx;
			endcase
			lum = q.tex[c].tex_freeze == FRZ_LIVE ? src_l : q.tex_mem[c][rd_idx];

			unique case (q.tex[c].vid_freeze)
				FRZ_FIELD1: rd_idx = {1'b0, wr_idx[FRZ_AW-1:0]};
				FRZ_FIELD2: rd_idx = {1'b1, wr_idx[FRZ_AW-1:0]};
				FRZ_FRAME: rd_idx = wr_idx;
				default: rd_idx = wr_idx;
			endcase
			vid_l = q.tex[c].vid_freeze == FRZ_LIVE ? ch[c].y : q.vid_mem[c][rd_idx];
			vid_y[c] = vid_l;

			if (q.tex[c].main_fn == TEX_INVERT) begin
				lum = ~lum;
			end

			// Height about mid grey plus offset, clipped at the byte limits.
			h = sat8(int'(lum) - LUMA_MID + int'(q.tex[c].offset));

			// Relief comes from the height change only, so flat areas of any
			// level leave the normal untouched. Line starts reset the history
			// to avoid a false step against the previous line's last pixel.
			hdiff = raster.line_start ? 0
				: int'(signed'(h)) - int'(signed'(q.h_prev[c]));
			slope = (int'(q.tex[c].gain) * hdiff) >>> GAIN_SHIFT;

			in_crop = raster.x >= q.crop_h[c].lo && raster.x <= q.crop_h[c].hi
				&& raster.y >= q.crop_v[c].lo && raster.y <= q.crop_v[c].hi;
			unique case (q.tex[c].crop)
				CROP_ON: apply = in_crop;
				CROP_INVERT: apply = ~in_crop;
				default: apply = 1'b1;
			endcase
			apply = apply && (q.tex[c].main_fn == TEX_ON
				|| q.tex[c].main_fn == TEX_INVERT);

			if (raster.valid) begin
				d.h_prev[c] = h;
				d.normal[c].ny = ch[c].ny;
				// Only the normal is bent; luma and key bypass this path.
				d.normal[c].nx = apply ? sat8(int'(ch[c].nx) + slope)
					: ch[c].nx;
				d.status[c] = apply;
			end
		end

		// Weight of the A-over-B composite, 0..256.
		if (q.ctrl.depth_mode) begin
			// Positive offsets pull the depth nearer without moving the picture.
			za = int'(ch[0].z) - int'(q.prio.a_offset) * Z_OFFSET_SCALE;
			zb = int'(ch[1].z) - int'(q.prio.b_offset) * Z_OFFSET_SCALE;
			// Per pixel depth, so tilted pictures win only where nearer.
			diff = zb - za;
			if (q.ctrl.z_soft == 3'(SOFT_HARD)) begin
				wa = diff > 0 ? WEIGHT_ONE : 0;
			end else begin
				wa = clampi(WEIGHT_HALF + (clampi(diff, -WEIGHT_ONE,
					WEIGHT_ONE) <<< q.ctrl.z_soft), 0, WEIGHT_ONE);
			end
		end else begin
			// Depth is ignored here; only the crossfade decides.
			wa = ((CROSSFADE_MAX - int'(q.ctrl.crossfade_amount)) * WEIGHT_ONE
				+ CROSSFADE_MAX / 2) / CROSSFADE_MAX;
		end

		ab = over(vid_y[0], ch[0].key, vid_y[1], ch[1].key);
		ba = over(vid_y[1], ch[1].key, vid_y[0], ch[0].key);

		// Both channels share this single output stage.
		d.out_valid = raster.valid;
		if (raster.valid) begin
			d.out_y = 8'((wa * int'(ab[7:0])
				+ (WEIGHT_ONE - wa) * int'(ba[7:0])) >> 8);
			d.out_key = 8'((wa * int'(ab[15:8])
				+ (WEIGHT_ONE - wa) * int'(ba[15:8])) >> 8);
			d.status[2] = wa < WEIGHT_HALF;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.ctrl <= CTRL_RST;
			q.prio <= PRIO_RST;
			q.tex[0] <= TEX_RST;
			q.tex[1] <= TEX_RST;
			q.crop_h[0] <= CROP_RST;
			q.crop_h[1] <= CROP_RST;
			q.crop_v[0] <= CROP_RST;
			q.crop_v[1] <= CROP_RST;
		end else begin
			q <= d;
		end
	end

	assign out_valid = q.out_valid;
	assign out_y = q.out_y;
	assign out_key = q.out_key;
	assign normal_a = q.normal[0];
	assign normal_b = q.normal[1];

endmodule // texture_combiner

// ---- tb/texture_combiner_checker.sv ----
// Checker on the combiner ports: pixel timing, priority and normals.
`timescale 1ns/10ps

module texture_combiner_checker
	import texture_combiner_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire raster_type raster,
	input wire chan_pixel_type chan_a,
	input wire chan_pixel_type chan_b,
	input wire logic out_valid,
	input wire logic [7:0] out_y,
	input wire logic [7:0] out_key,
	input wire normals_type normal_a
);
	typedef struct packed {
		ctrl_reg_type c;
		prio_reg_type p;
	} shadow_type;
	shadow_type sh_q;
	shadow_type sh_d;
	logic wr;
	logic zk;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////
	// Raw shadow of the mode words; clamped writes simply never match.
	assign wr = psel && penable && pwrite;
	assign zk = sh_q.c.depth_mode && sh_q.c.z_soft == 3'h7 && sh_q.p == '0;
	always_comb begin
		sh_d = sh_q;
		if (wr && paddr == CTRL_OFF) begin
			sh_d.c = pwdata;
		end
		if (wr && paddr == PRIO_OFF) begin
			sh_d.p = pwdata;
		end
	end

	// Taken on the same edge as the block, so both see the old word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_q <= '0;
		end else begin
			sh_q <= sh_d;
		end
	end

	// Both keys opaque, so the front channel shows exactly.
	sequence s_opaque;
		raster.valid && chan_a.key == 8'hFF && chan_b.key == 8'hFF;
	endsequence

	a_valid_follow: assert property (raster.valid |=> out_valid)
		else $error("Output valid missing after a pixel.");
	a_idle_hold: assert property (!raster.valid |=>
		!out_valid && $stable(out_y) && $stable(normal_a))
		else $error("Outputs moved on an idle cycle.");
	a_fixed_front: assert property (s_opaque ##0 (!sh_q.c.depth_mode &&
		sh_q.c.crossfade_amount == 7'h00) |=> out_y == $past(chan_a.y) &&
		out_key == 8'hFF)
		else $error("Channel A not in front at fade zero.");
	a_fade_full: assert property (s_opaque ##0 (!sh_q.c.depth_mode &&
		sh_q.c.crossfade_amount == 7'h64) |=> out_y == $past(chan_b.y))
		else $error("Channel B not in front at full fade.");
	a_depth_near_a: assert property (s_opaque ##0 (zk &&
		chan_a.z < chan_b.z) |=> out_y == $past(chan_a.y))
		else $error("Nearer channel A lost priority.");
	a_depth_near_b: assert property (s_opaque ##0 (zk &&
		chan_a.z > chan_b.z) |=> out_y == $past(chan_b.y))
		else $error("Nearer channel B lost priority.");
	a_line_flat: assert property (raster.valid && raster.line_start |=>
		normal_a.nx == $past(chan_a.nx))
		else $error("Normal bent on the first pixel of a line.");
	a_ny_pass: assert property (raster.valid |=>
		normal_a.ny == $past(chan_a.ny))
		else $error("Vertical normal altered.");
endmodule // texture_combiner_checker

bind texture_combiner texture_combiner_checker u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .raster(raster),
	.chan_a(chan_a), .chan_b(chan_b), .out_valid(out_valid),
	.out_y(out_y), .out_key(out_key), .normal_a(normal_a)
);

// ---- tb/texture_combiner_tb.sv ----
// Self-checking bench: register access, priority mixing, texture relief.
`timescale 1ns/10ps

module texture_combiner_tb
	import texture_combiner_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	raster_type raster = '0;
	chan_pixel_type chan_a = '0;
	chan_pixel_type chan_b = '0;
	tex_sources_type tex_src = '0;
	logic out_valid;
	logic [7:0] out_y;
	logic [7:0] out_key;
	normals_type normal_a;
	normals_type normal_b;
	int errors = 0;
	int comparisons = 0;
	int ao = 0;
	int bo = 0;
	int xfs [3] = '{0, 50, 100};
	int zs [3] = '{-5, 5, 100};
	int sf [3] = '{7, 3, 0};
	int gn [12] = '{4, 4, 0, -4, 4, 4, 4, 4, 4, 4, 4, 4};
	int of [12] = '{0, 0, 0, 0, 127, 0, 0, 0, 0, 0, 0, 0};
	int mn [12] = '{1, 2, 1, 1, 1, 1, 1, 0, 1, 1, 1, 1};
	int cr [12] = '{0, 0, 0, 0, 0, 1, 2, 0, 0, 0, 0, 0};
	int fz [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 3};
	int fl [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 1};
	logic [7:0] pat [2][6] = '{'{100, 100, 140, 140, 60, 255},
		'{0, 200, 200, 30, 30, 90}};
	logic [7:0] st [2][8];
	logic last_err = 1'b0;

	// Short freeze stripe keeps the store model small.
	texture_combiner #(.FRZ_PIXELS(8)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .raster(raster),
		.chan_a(chan_a), .chan_b(chan_b), .tex_src(tex_src),
		.out_valid(out_valid), .out_y(out_y), .out_key(out_key),
		.normal_a(normal_a), .normal_b(normal_b)
	);

	// Free-running pixel clock.
	always #50 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks.
	task automatic check(input string s, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Request held until pready is seen; released one cycle before reuse.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input string s);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		check(s, q, x);
	endtask

	// One pixel, then an idle cycle so results are read while held.
	task automatic px(input int za, input logic [7:0] lum, input int x,
		input logic f2);
		chan_a <= '{8'h20, 8'hFF, 16'(za), 8'sh0A, 8'sh05};
		chan_b <= '{8'hC0, 8'hFF, 16'sh0000, 8'sh03, 8'sh07};
		tex_src.ext[2] <= lum;
		tex_src.ext[0] <= ~lum;
		raster <= '{1'b1, x == 0, f2, 11'(x), 11'h002};
		@(posedge pclk);
		raster.valid <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic int sat(input int v);
		return v > 127 ? 127 : v < -128 ? -128 : v;
	endfunction

	function automatic int mix(input int w);
		return (w * 32 + (256 - w) * 192) >> 8;
	endfunction

	function automatic int wdep(input int d, input int s);
		if (s == 7) begin
			return d > 0 ? 256 : 0;
		end
		d = d > 256 ? 256 : d < -256 ? -256 : d;
		d = 128 + (d <<< s);
		return d > 256 ? 256 : d < 0 ? 0 : d;
	endfunction

	task automatic dtest(input int s, input int za);
		px(za, 8'h00, 1, 1'b0);
		check("depth y", out_y, mix(wdep(ao * 16 - bo * 16 - za, s)));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		int w;
		int l;
		int h;
		int hp;
		int hd;
		int e;
		logic [7:0] lv;
		logic ap;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CTRL_OFF, CTRL_RST, "ctrl");
		rd(PRIO_OFF, PRIO_RST, "prio");
		rd(TEX_A_OFF, TEX_RST, "tex a");
		rd(TEX_B_OFF, TEX_RST, "tex b");
		rd(8'h24, 32'h0000_0000, "hole");
		check("hole err", last_err, 1'b1);
		$display("Test registers done");
		foreach (xfs[i]) begin
			wr(CTRL_OFF, 32'(xfs[i]) << 4);
			px(500, 8'h00, 1, 1'b0);
			w = ((100 - xfs[i]) * 256 + 50) / 100;
			check("fixed y", out_y, mix(w));
		end
		wr(CTRL_OFF, 32'h0000_07F0);
		rd(CTRL_OFF, 32'h0000_0640, "fade clamp");
		$display("Test fixed done");
		foreach (sf[i]) begin
			wr(CTRL_OFF, 32'(sf[i]) << 1 | 32'h0000_0001);
			foreach (zs[j]) begin
				dtest(sf[i], zs[j]);
			end
		end
		wr(PRIO_OFF, 32'h0000_D85A);
		rd(PRIO_OFF, 32'h0000_CE64, "snap");
		ao = 100;
		bo = -50;
		wr(CTRL_OFF, 32'h0000_000F);
		dtest(7, 2000);
		dtest(7, 3000);
		$display("Test depth done");
		wr(CTRL_OFF, 32'h0000_0000);
		wr(CROP_A_H_OFF, 32'h0003_0001);
		// Frozen rows feed a flat live source, so only the store can bend.
		foreach (gn[i]) begin
			wr(TEX_A_OFF, {8'(gn[i]), 8'(of[i]), 8'h02, 2'(cr[i]), 2'b00,
				2'(fz[i]), 2'(mn[i])});
			for (int x = 0; x < 6; x++) begin
				lv = fz[i] != 0 ? 8'h77 : pat[fl[i]][x];
				l = fz[i] == 0 ? lv :
					st[fz[i] == 2 || (fz[i] == 3 && fl[i] == 1)][x];
				if (fz[i] == 0) begin
					st[fl[i]][x] = lv;
				end
				if (mn[i] == 2) begin
					l = 255 - l;
				end
				h = sat(l - 128 + of[i]);
				hd = x == 0 ? 0 : h - hp;
				hp = h;
				ap = mn[i] != 0 && (cr[i] == 0 || (cr[i] == 1) == (x >= 1 && x <= 3));
				e = ap ? sat(10 + (gn[i] * hd >>> 2)) : 10;
				px(0, lv, x, fl[i]);
				check("nx a", normal_a.nx, e);
				check("nx b", normal_b.nx, 3);
				check("image", out_y, 8'h20);
			end
		end
		$display("Test texture done");
		// Each internal source steps by its own amount, so a wrong select shows.
		for (int k = 0; k < 4; k++) begin
			wr(TEX_A_OFF, {8'h04, 8'h00, 4'h0, SRC_PATTERN + 4'(k), 8'h01});
			tex_src.pattern <= 8'h80;
			tex_src.defocus_a <= 8'h80;
			tex_src.defocus_b <= 8'h80;
			tex_src.matte <= 8'h80;
			px(0, 8'h00, 0, 1'b0);
			check("src flat", normal_a.nx, 10);
			tex_src.pattern <= 8'h90;
			tex_src.defocus_a <= 8'hA0;
			tex_src.defocus_b <= 8'hB0;
			tex_src.matte <= 8'hC0;
			px(0, 8'h00, 1, 1'b0);
			check("src nx", normal_a.nx, 10 + 16 * (k + 1));
		end
		rd(STATUS_OFF, 32'h0000_0001, "status");
		$display("Test sources done");
		wrap_up;
	end

	// The whole run needs well under a millisecond of simulated time.
	initial begin
		#1000000;
		errors++;
		wrap_up;
	end
endmodule // texture_combiner_tb
